// ===== logic/ipa_cfg.svh
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH
// ****************************************
// address and field layout
// ****************************************
`define IPA_ADDR_W        14           // linear data memory address width
`define IPA_BYTE_W        8            // width of each pointer byte register
`define IPA_NUM_PTR       3            // number of pointer pairs
`define IPA_HI_USED       6            // used bits of the high byte
// special function register addresses of the pointer bytes and operands
`define IPA_SFR_PTR0_LO   14'h3FE9
`define IPA_SFR_PTR0_HI   14'h3FEA
`define IPA_SFR_PTR1_LO   14'h3FE1
`define IPA_SFR_PTR1_HI   14'h3FE2
`define IPA_SFR_PTR2_LO   14'h3FD9
`define IPA_SFR_PTR2_HI   14'h3FDA
`define IPA_SFR_OPND0     14'h3FEF
`define IPA_SFR_OPND1     14'h3FE7
`define IPA_SFR_OPND2     14'h3FDF
// reset value of every pointer
`define IPA_PTR_RST       14'h0000
`endif

// ===== logic/ipa_pkg.sv
package ipa_pkg;
  // ****************************************
  // access modes of an indirect operand
  // ****************************************
  typedef enum logic [2:0] {
    IPA_MODE_PLAIN   = 3'b000,   // use pointer as is
    IPA_MODE_POSTINC = 3'b001,   // access then add one
    IPA_MODE_POSTDEC = 3'b010,   // access then subtract one
    IPA_MODE_PREINC  = 3'b011,   // add one then access
    IPA_MODE_OFFSET  = 3'b100    // pointer plus offset, pointer unchanged
  } ipa_mode_e;
  typedef logic [13:0] ipa_addr_t;  // linear data memory address
endpackage : ipa_pkg

// ===== logic/ipa_ptr_pair.sv
`timescale 1ns/10ps
`include "ipa_cfg.svh"
// ****************************************
// one pointer pair: high and low byte
// ****************************************
module ipa_ptr_pair (
  input  wire logic              mclk_i,      // core clock
  input  wire logic              sys_rst_i,   // sync reset, active high
  input  wire logic              wr_lo_i,     // direct write of low byte
  input  wire logic              wr_hi_i,     // direct write of high byte
  input  wire logic [7:0]        wdata_i,     // direct write data
  input  wire logic              upd_i,       // automatic update strobe
  input  wire ipa_pkg::ipa_addr_t upd_val_i,  // updated pointer value
  output logic      [13:0]       ptr_o        // current 14-bit pointer
);
  import ipa_pkg::*;
  logic [13:0] ptr_ff;      // pointer storage
  logic [13:0] nxt_ptr;     // next pointer value

  // an automatic update wins over a direct byte write to the same pair;
  // the cpu presents one address per cycle, so both never meet in practice
  assign nxt_ptr = upd_i   ? upd_val_i :
                   wr_lo_i ? {ptr_ff[13:8], wdata_i} :
                   wr_hi_i ? {wdata_i[5:0], ptr_ff[7:0]} :
                   ptr_ff;

  // register update
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ptr_ff <= `IPA_PTR_RST;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end
  assign ptr_o = ptr_ff;
endmodule : ipa_ptr_pair

// ===== logic/ipa_top.sv
`timescale 1ns/10ps
`include "ipa_cfg.svh"
module ipa_top (
  input  wire logic              mclk_i,       // core clock, 100 MHz
  input  wire logic              sys_rst_i,    // sync reset, active high
  input  wire logic              acc_vld_i,    // cpu data access this cycle
  input  wire logic              acc_wr_i,     // 1 write, 0 read
  input  wire ipa_pkg::ipa_addr_t acc_addr_i,  // cpu-resolved direct address
  input  wire logic [7:0]        acc_wdata_i,  // cpu write data
  input  wire ipa_pkg::ipa_mode_e acc_mode_i,  // operand access mode
  input  wire logic [7:0]        acc_ofs_i,    // signed offset for offset mode
  input  wire logic [7:0]        bank_sel_i,   // bank_select_value (ignored)
  input  wire logic              acc_bank_i,   // access bank bit (ignored)
  output logic                   acc_rvld_o,   // read data valid
  output logic      [7:0]        acc_rdata_o,  // read data to cpu
  output logic                   mem_en_o,     // data memory request
  output logic                   mem_wr_o,     // data memory write
  output logic      [13:0]       mem_addr_o,   // data memory address
  output logic      [7:0]        mem_wdata_o,  // data memory write data
  input  wire logic [7:0]        mem_rdata_i,  // data memory read data
  output logic      [41:0]       ptr_all_o     // all three pointers
);
  import ipa_pkg::*;

  // the unit sits between the cpu's resolved data access and the linear
  // data memory; it owns the three pointer pairs and nothing else
  // operand addresses carry no storage: every operand access is turned
  // into a memory access at the address the matching pointer gives
  // bank select and the access bank bit are accepted only so that the cpu
  // port stays uniform; a 14-bit pointer needs no bank to complete it

  // ****************************************
  // address decode
  // ****************************************
  // fixed addresses of the pointer bytes and the operands; a hit on any of
  // them is decided from the full 14-bit address, never from a bank offset
  localparam logic [13:0] LO_A [3] = '{`IPA_SFR_PTR0_LO, `IPA_SFR_PTR1_LO, `IPA_SFR_PTR2_LO};
  localparam logic [13:0] HI_A [3] = '{`IPA_SFR_PTR0_HI, `IPA_SFR_PTR1_HI, `IPA_SFR_PTR2_HI};
  localparam logic [13:0] OP_A [3] = '{`IPA_SFR_OPND0, `IPA_SFR_OPND1, `IPA_SFR_OPND2};

  // decode and selection nets
  logic [2:0]  hit_lo;          // direct hit on low byte
  logic [2:0]  hit_hi;          // direct hit on high byte
  logic [2:0]  hit_op;          // hit on indirect operand
  logic [2:0]  upd;             // pointer update strobe
  logic [13:0] ptr [3];         // live pointers
  logic [13:0] upd_val [3];     // updated pointer values
  logic [13:0] tgt [3];         // effective targets
  logic        any_op;          // operand selected
  logic        any_lo;          // low byte selected
  logic        any_hi;          // high byte selected
  logic [13:0] sel_ptr;         // pointer of selected operand
  logic [13:0] sel_tgt;         // target of selected operand
  logic [7:0]  sel_lo;          // selected low byte for read
  logic [7:0]  sel_hi;          // selected high byte for read
  logic [13:0] ofs_ext;         // sign-extended offset
  // read return state
  logic        pend_ff;         // memory read pending
  logic        reg_rd_ff;       // pointer byte read pending
  logic [7:0]  reg_dat_ff;      // captured pointer byte

  // offset mode takes a signed byte; extending it here lets one 14-bit adder
  // serve both forward and backward steps, and the sum wraps like the rest
  assign ofs_ext = {{6{acc_ofs_i[7]}}, acc_ofs_i};

  // one decode slice per pointer: byte hits, operand hit, target and the
  // pointer value left behind after the access
  // all three slices see the same mode, only the hit slice acts on it
  genvar g;
  generate
    for (g = 0; g < `IPA_NUM_PTR; g = g + 1) begin : g_ptr
      assign hit_lo[g] = acc_vld_i && (acc_addr_i == LO_A[g]);
      assign hit_hi[g] = acc_vld_i && (acc_addr_i == HI_A[g]);
      assign hit_op[g] = acc_vld_i && (acc_addr_i == OP_A[g]);
      // target: offset mode adds, pre-increment adds one; the sum wraps
      assign tgt[g] = (acc_mode_i == IPA_MODE_OFFSET)  ? 14'(ptr[g] + ofs_ext) :
                      (acc_mode_i == IPA_MODE_PREINC)  ? 14'(ptr[g] + 14'h0001) :
                      ptr[g];
      // new pointer after the access, modulo 14 bits
      assign upd_val[g] = (acc_mode_i == IPA_MODE_POSTDEC) ? 14'(ptr[g] - 14'h0001) :
                          (acc_mode_i == IPA_MODE_POSTINC) ? 14'(ptr[g] + 14'h0001) :
                          tgt[g];
      assign upd[g] = hit_op[g] && (acc_mode_i != IPA_MODE_PLAIN)
                      && (acc_mode_i != IPA_MODE_OFFSET);
      // one instance per pointer pair
      ipa_ptr_pair u_pair (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .wr_lo_i   (hit_lo[g] && acc_wr_i),
        .wr_hi_i   (hit_hi[g] && acc_wr_i),
        .wdata_i   (acc_wdata_i),
        .upd_i     (upd[g]),
        .upd_val_i (upd_val[g]),
        .ptr_o     (ptr[g])
      );
      assign ptr_all_o[14*g +: 14] = ptr[g];
    end
  endgenerate

  // ****************************************
  // selection
  // ****************************************
  // the cpu presents one address per cycle, so at most one hit bit is set;
  // the priority chains below only fix the idle value, they never arbitrate
  assign any_op = |hit_op;
  assign any_lo = |hit_lo;
  assign any_hi = |hit_hi;
  assign sel_tgt = hit_op[0] ? tgt[0] : hit_op[1] ? tgt[1] : tgt[2];
  assign sel_ptr = hit_op[0] ? ptr[0] : hit_op[1] ? ptr[1] : ptr[2];
  assign sel_lo  = hit_lo[0] ? ptr[0][7:0] : hit_lo[1] ? ptr[1][7:0] : ptr[2][7:0];
  // unused top bits of the high byte read as zero
  assign sel_hi  = hit_hi[0] ? {2'b00, ptr[0][13:8]} :
                   hit_hi[1] ? {2'b00, ptr[1][13:8]} : {2'b00, ptr[2][13:8]};

  // memory side: operand hits use the pointer target with no bank bits,
  // other addresses (not pointer bytes) pass straight through
  // the request is purely combinational so that memory sees the access in
  // the same cycle as the cpu; the cost is a longer path from the decode
  assign mem_en_o    = acc_vld_i && !any_lo && !any_hi;
  assign mem_wr_o    = acc_wr_i;
  assign mem_addr_o  = any_op ? sel_tgt : acc_addr_i;
  assign mem_wdata_o = acc_wdata_i;

  // ****************************************
  // read return, one cycle after request
  // ****************************************
  // read return pipeline: one flag for memory reads, one for pointer bytes
  // the pointer byte is captured at the request edge, so a same-cycle update
  // of that pointer cannot tear the value the cpu receives
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_ff    <= 1'b0;
      reg_rd_ff  <= 1'b0;
      reg_dat_ff <= 8'h00;
    end else begin
      pend_ff    <= mem_en_o && !acc_wr_i;
      reg_rd_ff  <= (any_lo || any_hi) && !acc_wr_i;
      reg_dat_ff <= any_lo ? sel_lo : sel_hi;
    end
  end

  // memory read data is held in memory's own output register
  // rdata is forced to zero between answers so a stale byte never looks
  // like a fresh one to a cpu that ignores the valid flag
  assign acc_rvld_o  = pend_ff || reg_rd_ff;
  assign acc_rdata_o = reg_rd_ff ? reg_dat_ff : (pend_ff ? mem_rdata_i : 8'h00);

  // ****************************************
  // checks
  // ****************************************
  // each check names one pointer or all of them; together the three slices
  // are watched, and the reset window is left out because the pointers are
  // being forced to zero there

  // plain operand access must land exactly on the pointer value
  a_opnd_target: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    any_op && acc_mode_i == IPA_MODE_PLAIN |-> mem_addr_o == sel_ptr)
    else $error("operand not routed to its pointer");
  // post increment steps the pointer by one, wrapping at the top
  a_postinc_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_op[1] && acc_mode_i == IPA_MODE_POSTINC |=> ptr[1] == 14'($past(ptr[1]) + 14'h0001))
    else $error("post increment did not advance pointer");
  // post decrement uses the old pointer, then steps down with wrap
  a_postdec_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_op[2] && acc_mode_i == IPA_MODE_POSTDEC
      |-> mem_addr_o == ptr[2] ##1 ptr[2] == 14'($past(ptr[2]) - 14'h0001))
    else $error("post decrement wrong");
  // offset mode adds the signed byte and leaves the pointer alone
  a_offset_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_op[0] && acc_mode_i == IPA_MODE_OFFSET
      |-> mem_addr_o == 14'(ptr[0] + ofs_ext) ##1 $stable(ptr[0]))
    else $error("offset access wrong");
  // operand hits always reach memory at the pointer-derived target
  a_bank_ignore: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    any_op |-> mem_addr_o == sel_tgt && mem_en_o)
    else $error("operand address depends on bank");
  // the two unused high bits read back as zero
  a_hi_unused: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_hi[0] && !acc_wr_i |=> acc_rvld_o && acc_rdata_o[7:6] == 2'b00)
    else $error("unused high bits not zero");
  // a direct low byte write lands in the pointer
  a_lo_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_lo[1] && acc_wr_i |=> ptr[1][7:0] == $past(acc_wdata_i))
    else $error("low byte write lost");
  // operand reads return what memory returns, nothing held locally
  a_no_storage: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    any_op && !acc_wr_i |=> acc_rvld_o && acc_rdata_o == mem_rdata_i)
    else $error("operand read not from memory");

  // pre-increment addresses one past the pointer, with 14-bit wrap
  a_preinc_target: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    any_op && acc_mode_i == IPA_MODE_PREINC |-> mem_addr_o == 14'(sel_ptr + 14'h0001))
    else $error("pre increment address wrong");
  // plain mode must leave the pointer untouched
  a_plain_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_op[2] && acc_mode_i == IPA_MODE_PLAIN |=> $stable(ptr[2]))
    else $error("plain access moved pointer");
  // pointer bytes are served here and never reach the data memory
  a_byte_no_mem: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (any_lo || any_hi) |-> !mem_en_o)
    else $error("pointer byte access leaked to memory");
  // a high byte write keeps only its six used bits
  a_hi_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hit_hi[2] && acc_wr_i |=> {2'b00, ptr[2][13:8]} == ($past(acc_wdata_i) & 8'h3F))
    else $error("high byte write wrong");
  // every read is answered exactly one cycle later
  a_rd_answer: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    acc_vld_i && !acc_wr_i |=> acc_rvld_o)
    else $error("read not answered");

  // ****************************************
  // coverage of the main scenarios
  // ****************************************
  // every mode on every pointer is driven, so each of these should be seen
  c_postinc: cover property (@(posedge mclk_i) hit_op[0] && acc_mode_i == IPA_MODE_POSTINC);
  c_offset: cover property (@(posedge mclk_i) hit_op[2] && acc_mode_i == IPA_MODE_OFFSET);
  c_hi_write: cover property (@(posedge mclk_i) hit_hi[1] && acc_wr_i);
  c_wrap: cover property (@(posedge mclk_i) upd[0] && ptr[0] == 14'h3FFF);
  c_postdec: cover property (@(posedge mclk_i) hit_op[1] && acc_mode_i == IPA_MODE_POSTDEC);
endmodule : ipa_top

// ===== sim/ipa_mem_model.sv
`timescale 1ns/10ps
// ****************************************
// linear data memory beyond the unit
// ****************************************
module ipa_mem_model (
  input  wire logic        mclk_i,   // core clock
  input  wire logic        en_i,     // request
  input  wire logic        wr_i,     // 1 write, 0 read
  input  wire logic [13:0] addr_i,   // linear address, no banks
  input  wire logic [7:0]  wdata_i,  // write data
  output logic      [7:0]  rdata_o   // valid only the cycle after a read
);
  logic [7:0] mem_q [0:16383];  // whole linear space
  initial rdata_o = 8'h00;
  // idle cycles invert the bus so that stale data never passes for fresh
  always @(posedge mclk_i) begin
    if (en_i && wr_i) mem_q[addr_i] <= wdata_i;
    rdata_o <= (en_i && !wr_i) ? mem_q[addr_i] : ~rdata_o;
  end
endmodule : ipa_mem_model

// ===== sim/indirect_pointer_addressing_tb.sv
`timescale 1ns/10ps
`include "ipa_cfg.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module indirect_pointer_addressing_tb;
  import ipa_pkg::*;
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1, acc_vld_i = 1'b0, acc_wr_i = 1'b0;
  logic        acc_bank_i = 1'b0, acc_rvld_o, mem_en_o, mem_wr_o, s_en, s_wr, s_rv;
  logic [13:0] acc_addr_i = '0, mem_addr_o, s_addr;
  logic [7:0]  acc_wdata_i = '0, acc_ofs_i = '0, bank_sel_i = '0, mem_rdata_i;
  logic [7:0]  acc_rdata_o, mem_wdata_o, s_wd, s_rd;
  logic [41:0] ptr_all_o;
  ipa_mode_e   acc_mode_i = IPA_MODE_PLAIN;
  int          bad_count = 0, checks_done = 0, cyc = 0;
  // per pointer: low byte address and operand address
  localparam logic [13:0] LO_A[3] = '{`IPA_SFR_PTR0_LO, `IPA_SFR_PTR1_LO, `IPA_SFR_PTR2_LO};
  localparam logic [13:0] OP_A[3] = '{`IPA_SFR_OPND0, `IPA_SFR_OPND1, `IPA_SFR_OPND2};
  // mode table: start pointer, offset, expected address, expected pointer after
  localparam ipa_mode_e MD[5] = '{IPA_MODE_PLAIN, IPA_MODE_POSTINC, IPA_MODE_POSTDEC,
                                   IPA_MODE_PREINC, IPA_MODE_OFFSET};
  localparam logic [13:0] ST[5] = '{14'h1234, 14'h3FFF, 14'h0000, 14'h3FFF, 14'h0010};
  localparam logic [7:0]  OF[5] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'hF0};
  localparam logic [13:0] EA[5] = '{14'h1234, 14'h3FFF, 14'h0000, 14'h0000, 14'h0000};
  localparam logic [13:0] EP[5] = '{14'h1234, 14'h0000, 14'h3FFF, 14'h0000, 14'h0010};

  ipa_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .acc_vld_i(acc_vld_i),
    .acc_wr_i(acc_wr_i), .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_mode_i(acc_mode_i), .acc_ofs_i(acc_ofs_i), .bank_sel_i(bank_sel_i),
    .acc_bank_i(acc_bank_i), .acc_rvld_o(acc_rvld_o), .acc_rdata_o(acc_rdata_o),
    .mem_en_o(mem_en_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .ptr_all_o(ptr_all_o));
  ipa_mem_model mem (.mclk_i(mclk_i), .en_i(mem_en_o), .wr_i(mem_wr_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  always #5 mclk_i = ~mclk_i;
  // hang guard: the bench's 69 accesses fit well inside this ceiling
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // one access, entered just after an edge; bank inputs vary so ignoring them is tested
  task automatic acc(input logic w, input logic [13:0] a, input logic [7:0] d,
                     input ipa_mode_e m, input logic [7:0] o);
    {acc_vld_i, acc_wr_i, acc_addr_i, acc_wdata_i, acc_ofs_i} = {1'b1, w, a, d, o};
    {bank_sel_i, acc_bank_i} = {~a[7:0], ~a[0]};
    acc_mode_i = m;
    #1;
    {s_en, s_wr, s_addr, s_wd} = {mem_en_o, mem_wr_o, mem_addr_o, mem_wdata_o};
    @(posedge mclk_i);
    #1;
    {s_rv, s_rd} = {acc_rvld_o, acc_rdata_o};
  endtask : acc
  task automatic idle;
    acc_vld_i = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask : idle
  task automatic set_ptr(input int n, input logic [13:0] v);
    acc(1'b1, LO_A[n], v[7:0], IPA_MODE_PLAIN, 8'h00);
    acc(1'b1, LO_A[n] + 14'h0001, {2'b11, v[13:8]}, IPA_MODE_PLAIN, 8'h00);
  endtask : set_ptr
  // pointer bytes written directly, high bytes read back, top bits dropped
  task automatic t_bytes;
    logic [41:0] exp;
    for (int n = 0; n < 3; n++) begin
      exp[n*14 +: 14] = {6'(n + 1), 8'h30 + 8'(n)};
      set_ptr(n, exp[n*14 +: 14]);
      `CHK("ptr_wr_mem", 1'b0, s_en)
      acc(1'b0, LO_A[n] + 14'h0001, 8'h00, IPA_MODE_PLAIN, 8'h00);
      `CHK("hi_rvld", 1'b1, s_rv)
      `CHK("hi_read", 8'(n + 1), s_rd)
    end
    idle();
    `CHK("ptr_all", exp, ptr_all_o)
  endtask : t_bytes
  // operand access lands at the pointed linear location
  task automatic t_operand;
    for (int n = 0; n < 3; n++) begin
      set_ptr(n, 14'h2100 + 14'(n * 3));
      acc(1'b1, OP_A[n], 8'h5A ^ 8'(n), IPA_MODE_PLAIN, 8'h00);
      `CHK("op_wr_addr", 14'h2100 + 14'(n * 3), s_addr)
      `CHK("op_wr_req", 2'b11, {s_en, s_wr})
      `CHK("op_wdata", 8'h5A ^ 8'(n), s_wd)
      acc(1'b0, OP_A[n], 8'h00, IPA_MODE_PLAIN, 8'h00);
      `CHK("op_rd_addr", 14'h2100 + 14'(n * 3), s_addr)
      `CHK("op_rdata", {1'b1, 8'h5A ^ 8'(n)}, {s_rv, s_rd})
      acc(1'b0, 14'h2100 + 14'(n * 3), 8'h00, IPA_MODE_PLAIN, 8'h00);
      `CHK("linear_rd", 8'h5A ^ 8'(n), s_rd)
    end
    idle();
  endtask : t_operand
  // every mode on every pointer, with wrap at both ends of the 14-bit space
  task automatic t_modes;
    for (int i = 0; i < 5; i++) begin
      for (int n = 0; n < 3; n++) begin
        set_ptr(n, ST[i]);
        acc(1'b0, OP_A[n], 8'h00, MD[i], OF[i]);
        `CHK("mode_addr", EA[i], s_addr)
        `CHK("mode_ptr", EP[i], ptr_all_o[n*14 +: 14])
      end
    end
    idle();
  endtask : t_modes
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    `CHK("ptr_rst", {3{`IPA_PTR_RST}}, ptr_all_o)
    t_bytes();
    t_operand();
    t_modes();
    report_and_stop();
  end
endmodule : indirect_pointer_addressing_tb
